// *** rtl/sequence_function_blocks.sv ***
// evaluator for the select, bit, smoothing, regulator and counter blocks
// assumes a sequencer on the same clock issues one step per block per loop
`include "seq_blocks_defs.svh"
module sequence_function_blocks (
  // clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // step request
  input  wire logic        step_i,
  input  wire logic        loop_start_i,
  input  wire logic [7:0]  op_code_i,
  input  wire logic [15:0] arg_a_i,
  input  wire logic [15:0] arg_b_i,
  input  wire logic [15:0] arg_c_i,
  // answer
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      result_o
);

  seq_blocks_pkg::eval_state_e state_q, state_d;
  seq_blocks_pkg::word_t a_q, a_d, b_q, b_d, c_q, c_d, result_d;
  seq_blocks_pkg::word_t kp_q, kp_d, ti_q, ti_d, up_q, up_d, dn_q, dn_d;
  logic [7:0]         op_q, op_d, last_q, last_d;
  logic               chain_q, chain_d, gain_ok_q, gain_ok_d;
  logic [1:0]         mode_q, mode_d;
  logic               up_prev_q, up_prev_d, dn_prev_q, dn_prev_d;
  logic signed [31:0] lpf_q, lpf_d, integ_q, integ_d;
  logic               done_d, busy_d;
  logic               div_start, div_done;
  logic signed [55:0] div_num, div_quo;
  logic [23:0]        div_den;
  logic signed [55:0] e_x, kp_x, ti_x, sc_x, in_x, lim_x, lo_x;
  logic signed [32:0] isum;
  logic               a_on, up_hit;

  ////////////////////////////////////////////////////////////////////////
  // bit position to mask, shared by three blocks
  function automatic seq_blocks_pkg::word_t bit_mask(seq_blocks_pkg::word_t b);
    seq_blocks_pkg::word_t pos;
    pos = (b > `SFB_BIT_MAX) ? `SFB_BIT_MAX : b;
    if (pos == 16'h0000) return 16'h0000;
    return 16'h0001 << (pos - 16'h0001);
  endfunction

  serial_divider #(.NW(56), .DW(24)) u_div (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .start_i   (div_start),
    .num_i     (div_num),
    .den_i     (div_den),
    .done_o    (div_done),
    .quo_o     (div_quo)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    op_d = op_q;      a_d = a_q;       b_d = b_q;       c_d = c_q;
    last_d = last_q;  chain_d = chain_q;
    kp_d = kp_q;      ti_d = ti_q;     mode_d = mode_q; gain_ok_d = gain_ok_q;
    up_d = up_q;      dn_d = dn_q;     up_prev_d = up_prev_q;
    dn_prev_d = dn_prev_q;
    lpf_d = lpf_q;    integ_d = integ_q;
    result_d = result_o;
    done_d = 1'b0;
    div_start = 1'b0;
    div_num = '0;
    div_den = 24'h000001;
    a_on = (a_q != 16'h0000);
    e_x  = 56'(signed'(a_q));
    kp_x = 56'(kp_q);
    ti_x = 56'(ti_q);
    sc_x = 56'(`SFB_P_SCALE);
    isum = 33'(integ_q) + 33'(signed'(a_q));
    in_x = 56'(integ_q);
    lim_x = 56'(b_q[15] ? `SFB_CNT_MAX : b_q);
    lo_x  = (mode_q == 2'(`SFB_MODE_POS)) ? 56'sd0 : -lim_x;
    case (c_q)
      `SFB_EDGE_RISE: up_hit = a_on && !up_prev_q;
      `SFB_EDGE_FALL: up_hit = !a_on && up_prev_q;
      `SFB_EDGE_ANY:  up_hit = a_on != up_prev_q;
      default:        up_hit = 1'b0;
    endcase
    case (state_q)
      seq_blocks_pkg::ST_IDLE: begin
        if (step_i) begin
          op_d = op_code_i;
          a_d = arg_a_i;
          b_d = arg_b_i;
          c_d = arg_c_i;
          // only an immediately preceding gain stage arms the output stage
          chain_d = !loop_start_i && (last_q == `SFB_OP_GAIN);
          last_d = op_code_i;
          state_d = seq_blocks_pkg::ST_EXEC;
        end
      end
      seq_blocks_pkg::ST_EXEC: begin
        state_d = seq_blocks_pkg::ST_IDLE;
        done_d = 1'b1;
        case (op_q)
          `SFB_OP_SWITCH: result_d = (a_q == 16'h0000) ? c_q : b_q;
          `SFB_OP_PROBE:  result_d = {15'h0000, |(a_q & bit_mask(b_q))};
          `SFB_OP_RAISE:
            result_d = (b_q == 16'h0000) ? 16'h0000 : (a_q | bit_mask(b_q));
          `SFB_OP_DROP:
            result_d = (b_q == 16'h0000) ? 16'h0000 : (a_q & ~bit_mask(b_q));
          `SFB_OP_SMOOTH: begin
            if (c_q != 16'h0000) begin
              result_d = lpf_q[31:16];
            end else if (b_q == 16'h0000) begin
              lpf_d = {a_q, 16'h0000};
              result_d = a_q;
            end else begin
              // y += (x - y) / B each loop, fraction kept in low half
              // both sides zero-extended and signed in 33 bits so a falling input gives a negative step
              div_num = 56'($signed({1'b0, a_q, 16'h0000}) - $signed({1'b0, lpf_q}));
              div_den = {8'h00, b_q};
              div_start = 1'b1;
              done_d = 1'b0;
              state_d = seq_blocks_pkg::ST_DIVW;
            end
          end
          `SFB_OP_GAIN: begin
            kp_d = a_q;
            ti_d = b_q;
            mode_d = c_q[1:0];
            gain_ok_d = (b_q != 16'h0000) && (c_q <= `SFB_MODE_SYM);
            result_d = gain_ok_d ? 16'h0000 : `SFB_RESULT_ERR;
          end
          `SFB_OP_OUTSTG: begin
            if (!(chain_q && gain_ok_q)) begin
              result_d = 16'h0000;
            end else if (mode_q == 2'(`SFB_MODE_CONST)) begin
              result_d = c_q[15] ? `SFB_CNT_MAX : c_q;
            end else begin
              // integrator saturates to keep the numerator inside 56 bits
              // limit compared signed, else a negative sum reads as huge
              if (isum > $signed(`SFB_INT_LIM)) integ_d = 32'($signed(`SFB_INT_LIM));
              else if (isum < -$signed(`SFB_INT_LIM)) integ_d = 32'(-$signed(`SFB_INT_LIM));
              else integ_d = 32'(isum);
              in_x = 56'(integ_d);
              // (e*A*B + 100*S) / (100*B) gives both gains in one divide
              div_num = e_x * kp_x * ti_x + sc_x * in_x;
              div_den = `SFB_P_SCALE * {8'h00, ti_q};
              div_start = 1'b1;
              done_d = 1'b0;
              state_d = seq_blocks_pkg::ST_DIVW;
            end
          end
          `SFB_OP_UPCNT: begin
            up_prev_d = a_on;
            if (b_q != 16'h0000) up_d = 16'h0000;
            else if (up_hit && up_q < `SFB_CNT_MAX) up_d = up_q + 16'h0001;
            result_d = up_d;
          end
          `SFB_OP_DNCNT: begin
            dn_prev_d = a_on;
            if (b_q != 16'h0000) dn_d = c_q;
            else if (a_on && !dn_prev_q && dn_q != 16'h0000) dn_d = dn_q - 16'h0001;
            result_d = dn_d;
          end
          default: result_d = 16'h0000;
        endcase
      end
      seq_blocks_pkg::ST_DIVW: begin
        if (div_done) state_d = seq_blocks_pkg::ST_FINISH;
      end
      seq_blocks_pkg::ST_FINISH: begin
        state_d = seq_blocks_pkg::ST_IDLE;
        done_d = 1'b1;
        if (op_q == `SFB_OP_SMOOTH) begin
          lpf_d = lpf_q + div_quo[31:0];
          result_d = lpf_d[31:16];
        end else if (div_quo > lim_x) begin
          result_d = 16'(lim_x);
        end else if (div_quo < lo_x) begin
          result_d = 16'(lo_x);
        end else begin
          result_d = 16'(div_quo);
        end
      end
      default: state_d = seq_blocks_pkg::ST_IDLE;
    endcase
    busy_d = (state_d != seq_blocks_pkg::ST_IDLE);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= seq_blocks_pkg::ST_IDLE;
      op_q <= 8'h00;         last_q <= 8'h00;       chain_q <= 1'b0;
      a_q <= `SFB_RST_WORD;  b_q <= `SFB_RST_WORD;  c_q <= `SFB_RST_WORD;
      kp_q <= `SFB_RST_WORD; ti_q <= `SFB_RST_WORD; mode_q <= 2'h0;
      gain_ok_q <= 1'b0;
      up_q <= `SFB_RST_WORD; dn_q <= `SFB_RST_WORD;
      up_prev_q <= 1'b0;     dn_prev_q <= 1'b0;
      lpf_q <= `SFB_RST_ACC; integ_q <= `SFB_RST_ACC;
      result_o <= `SFB_RST_WORD;
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      op_q <= op_d;          last_q <= last_d;      chain_q <= chain_d;
      a_q <= a_d;            b_q <= b_d;            c_q <= c_d;
      kp_q <= kp_d;          ti_q <= ti_d;          mode_q <= mode_d;
      gain_ok_q <= gain_ok_d;
      up_q <= up_d;          dn_q <= dn_d;
      up_prev_q <= up_prev_d; dn_prev_q <= dn_prev_d;
      lpf_q <= lpf_d;        integ_q <= integ_d;
      result_o <= result_d;
      done_o <= done_d;
      busy_o <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks against the captured operands, which hold until the next step
  a_switch_pick: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done_o && op_q == `SFB_OP_SWITCH |-> result_o == ((a_q == 16'h0000) ? c_q : b_q))
    else $error("select block output wrong");
  a_probe_zero_b: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done_o && op_q == `SFB_OP_PROBE && b_q == 16'h0000 |-> result_o == 16'h0000)
    else $error("bit probe with zero position not zero");
  a_raise_msb: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done_o && op_q == `SFB_OP_RAISE && b_q >= `SFB_BIT_MAX |-> result_o[15] && result_o[14:0] == a_q[14:0])
    else $error("bit raise at top position wrong");
  a_drop_lsb: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done_o && op_q == `SFB_OP_DROP && b_q == 16'h0001 |-> result_o == {a_q[15:1], 1'b0})
    else $error("bit drop at first position wrong");
  a_smooth_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && state_q == seq_blocks_pkg::ST_EXEC && op_q == `SFB_OP_SMOOTH && c_q != 16'h0000
    |=> done_o && result_o == $past(lpf_q[31:16]))
    else $error("smoothing ran while stopped");
  a_gain_invalid: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done_o && op_q == `SFB_OP_GAIN && b_q == 16'h0000 |-> result_o == `SFB_RESULT_ERR)
    else $error("invalid gain settings not flagged");
  a_chain_broken: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done_o && op_q == `SFB_OP_OUTSTG && !chain_q |-> result_o == 16'h0000)
    else $error("output stage regulated without gain stage");
  a_limit_pos: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done_o && op_q == `SFB_OP_OUTSTG && chain_q && gain_ok_q && mode_q == 2'h1
    |-> !result_o[15] && 56'(result_o) <= lim_x)
    else $error("positive limit mode out of range");
  a_up_idle: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done_o && op_q == `SFB_OP_UPCNT && b_q != 16'h0000 |-> result_o == 16'h0000 && up_q == 16'h0000)
    else $error("up counter active while disabled");
  a_up_range: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    up_q <= `SFB_CNT_MAX)
    else $error("up counter above range");
  a_down_preset: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done_o && op_q == `SFB_OP_DNCNT && b_q != 16'h0000 |-> result_o == c_q)
    else $error("down counter not showing preset");
  a_down_step: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && state_q == seq_blocks_pkg::ST_EXEC && op_q == `SFB_OP_DNCNT && b_q == 16'h0000
    && a_on && !dn_prev_q && dn_q != 16'h0000 |=> dn_q == $past(dn_q) - 16'h0001)
    else $error("down counter missed rising edge");

endmodule

// *** rtl/seq_blocks_defs.svh ***
// constants shared by the sequence function block evaluator
// assumes every file that needs them includes this header by its bare name
`ifndef SEQ_BLOCKS_DEFS_SVH
`define SEQ_BLOCKS_DEFS_SVH

// block codes
`define SFB_OP_SWITCH   8'h14
`define SFB_OP_PROBE    8'h15
`define SFB_OP_RAISE    8'h16
`define SFB_OP_DROP     8'h17
`define SFB_OP_SMOOTH   8'h18
`define SFB_OP_GAIN     8'h19
`define SFB_OP_OUTSTG   8'h1A
`define SFB_OP_UPCNT    8'h1B
`define SFB_OP_DNCNT    8'h1C

// operand limits and encodings
`define SFB_BIT_MAX     16'h0010
`define SFB_CNT_MAX     16'h7FFF
`define SFB_P_SCALE     24'h000064
`define SFB_MODE_CONST  16'h0000
`define SFB_MODE_POS    16'h0001
`define SFB_MODE_SYM    16'h0002
`define SFB_EDGE_RISE   16'h0000
`define SFB_EDGE_FALL   16'h0001
`define SFB_EDGE_ANY    16'h0002
`define SFB_RESULT_ERR  16'hFFFF
`define SFB_INT_LIM     33'h040000000

// reset values
`define SFB_RST_WORD    16'h0000
`define SFB_RST_ACC     32'h00000000

`endif

// *** rtl/seq_blocks_pkg.sv ***
// types shared by the sequence function block evaluator
// assumes nothing beyond a SystemVerilog compiler
package seq_blocks_pkg;

  typedef logic [15:0] word_t;

  // gray along idle -> exec -> divide -> finish -> idle
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_EXEC   = 2'h1,
    ST_DIVW   = 2'h3,
    ST_FINISH = 2'h2
  } eval_state_e;

endpackage

// *** rtl/serial_divider.sv ***
// restoring serial divider, signed numerator over positive denominator
// assumes den_i is nonzero and held stable only at start_i
module serial_divider #(
  parameter int NW = 56,
  parameter int DW = 24
) (
  // clock, reset and enable
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  // request
  input  wire logic                 start_i,
  input  wire logic signed [NW-1:0] num_i,
  input  wire logic        [DW-1:0] den_i,
  // answer
  output logic                      done_o,
  output logic signed [NW-1:0]      quo_o
);

  localparam int CW = $clog2(NW + 1);

  logic [DW:0]   rem_q,  rem_d;
  logic [NW-1:0] mag_q,  mag_d;
  logic [DW-1:0] den_q,  den_d;
  logic [CW-1:0] cnt_q,  cnt_d;
  logic          neg_q,  neg_d;
  logic          act_q,  act_d;
  logic          done_d;
  logic [NW-1:0] quo_d;
  logic [DW:0]   trial;

  always_comb begin
    rem_d  = rem_q;
    mag_d  = mag_q;
    den_d  = den_q;
    cnt_d  = cnt_q;
    neg_d  = neg_q;
    act_d  = act_q;
    done_d = 1'b0;
    quo_d  = quo_o;
    trial  = {rem_q[DW-1:0], mag_q[NW-1]};
    if (start_i) begin
      neg_d = num_i[NW-1];
      mag_d = num_i[NW-1] ? NW'(-num_i) : NW'(num_i);
      rem_d = '0;
      den_d = den_i;
      cnt_d = CW'(NW);
      act_d = 1'b1;
    end else if (act_q) begin
      if (trial >= {1'b0, den_q}) begin
        rem_d = trial - {1'b0, den_q};
        mag_d = {mag_q[NW-2:0], 1'b1};
      end else begin
        rem_d = trial;
        mag_d = {mag_q[NW-2:0], 1'b0};
      end
      cnt_d = cnt_q - CW'(1);
      if (cnt_q == CW'(1)) begin
        act_d  = 1'b0;
        done_d = 1'b1;
        // quotient truncates toward zero
        quo_d  = neg_q ? NW'(-mag_d) : mag_d;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rem_q  <= '0;
      mag_q  <= '0;
      den_q  <= '0;
      cnt_q  <= '0;
      neg_q  <= 1'b0;
      act_q  <= 1'b0;
      done_o <= 1'b0;
      quo_o  <= '0;
    end else if (ce_i) begin
      rem_q  <= rem_d;
      mag_q  <= mag_d;
      den_q  <= den_d;
      cnt_q  <= cnt_d;
      neg_q  <= neg_d;
      act_q  <= act_d;
      done_o <= done_d;
      quo_o  <= quo_d;
    end
  end

endmodule

// *** tb/testbench.sv ***
// self-checking bench for the sequence function block evaluator
// assumes the design header defines the block codes; drives every input itself
`include "seq_blocks_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk;
  logic        rst_n;
  logic        ce;
  logic        step;
  logic        loop_start;
  logic [7:0]  op_code;
  logic [15:0] arg_a;
  logic [15:0] arg_b;
  logic [15:0] arg_c;
  logic        busy;
  logic        done;
  logic [15:0] result;
  int          errors;
  int          comparisons;

  ////////////////////////////////////////////////////////////////////////////
  sequence_function_blocks dut (
    .ref_clk_i    (ref_clk),
    .rst_n_i      (rst_n),
    .ce_i         (ce),
    .step_i       (step),
    .loop_start_i (loop_start),
    .op_code_i    (op_code),
    .arg_a_i      (arg_a),
    .arg_b_i      (arg_b),
    .arg_c_i      (arg_c),
    .busy_o       (busy),
    .done_o       (done),
    .result_o     (result)
  );

  always #50 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // entered just after a rising edge; returns just after the done edge
  task automatic expect_op(input string name, input logic [7:0] op, input logic [15:0] a,
                           input logic [15:0] b, input logic [15:0] c, input logic first,
                           input logic [15:0] exp);
    int n;
    op_code = op;
    arg_a = a;
    arg_b = b;
    arg_c = c;
    loop_start = first;
    step = 1'b1;
    @(posedge ref_clk);
    #1;
    step = 1'b0;
    loop_start = 1'b0;
    check_word({name, " busy"}, 16'h0001, {15'h0000, busy});
    n = 0;
    // divide steps need 59 edges, so 100 leaves margin without hiding a hang
    while (done !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check_word({name, " done"}, 16'h0001, {15'h0000, done});
    check_word({name, " idle"}, 16'h0000, {15'h0000, busy});
    check_word(name, exp, result);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic select_case();
    expect_op("select a1", `SFB_OP_SWITCH, 16'h0001, 16'h1234, 16'h5678, 1'b1, 16'h1234);
    expect_op("select a0", `SFB_OP_SWITCH, 16'h0000, 16'h1234, 16'h5678, 1'b0, 16'h5678);
    expect_op("unknown", 8'h30, 16'h0001, 16'h0002, 16'h0003, 1'b0, 16'h0000);
  endtask

  task automatic bit_case();
    expect_op("probe b0", `SFB_OP_PROBE, 16'h8001, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    expect_op("probe b1", `SFB_OP_PROBE, 16'h8001, 16'h0001, 16'h0000, 1'b0, 16'h0001);
    expect_op("probe b2", `SFB_OP_PROBE, 16'h8001, 16'h0002, 16'h0000, 1'b0, 16'h0000);
    expect_op("probe b16", `SFB_OP_PROBE, 16'h8001, 16'h0010, 16'h0000, 1'b0, 16'h0001);
    expect_op("probe b20", `SFB_OP_PROBE, 16'h8000, 16'h0014, 16'h0000, 1'b0, 16'h0001);
    expect_op("raise b0", `SFB_OP_RAISE, 16'h0F00, 16'h0000, 16'hFFFF, 1'b0, 16'h0000);
    expect_op("raise b1", `SFB_OP_RAISE, 16'h0F00, 16'h0001, 16'hFFFF, 1'b0, 16'h0F01);
    expect_op("raise b20", `SFB_OP_RAISE, 16'h0F00, 16'h0014, 16'h0000, 1'b0, 16'h8F00);
    expect_op("drop b0", `SFB_OP_DROP, 16'hFFFF, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    expect_op("drop b1", `SFB_OP_DROP, 16'hFFFF, 16'h0001, 16'h1111, 1'b0, 16'hFFFE);
    expect_op("drop b16", `SFB_OP_DROP, 16'hFFFF, 16'h0010, 16'h0000, 1'b0, 16'h7FFF);
  endtask

  task automatic smooth_case();
    expect_op("smooth t1", `SFB_OP_SMOOTH, 16'h0064, 16'h0001, 16'h0000, 1'b0, 16'h0064);
    expect_op("smooth hold", `SFB_OP_SMOOTH, 16'h01F4, 16'h0001, 16'h0001, 1'b0, 16'h0064);
    expect_op("smooth t2", `SFB_OP_SMOOTH, 16'h012C, 16'h0002, 16'h0000, 1'b0, 16'h00C8);
    expect_op("smooth t2b", `SFB_OP_SMOOTH, 16'h012C, 16'h0002, 16'h0000, 1'b0, 16'h00FA);
  endtask

  // kp 1.00 and a slow integrator keep the integral part below one count
  task automatic regulator_case();
    expect_op("gain sym", `SFB_OP_GAIN, 16'h0064, 16'h7530, 16'h0002, 1'b0, 16'h0000);
    expect_op("out sym", `SFB_OP_OUTSTG, 16'h0032, 16'h0064, 16'h0000, 1'b0, 16'h0032);
    expect_op("gain pos", `SFB_OP_GAIN, 16'h0064, 16'h7530, 16'h0001, 1'b0, 16'h0000);
    expect_op("out pos hi", `SFB_OP_OUTSTG, 16'h0032, 16'h0014, 16'h0000, 1'b0, 16'h0014);
    expect_op("gain pos", `SFB_OP_GAIN, 16'h0064, 16'h7530, 16'h0001, 1'b0, 16'h0000);
    expect_op("out pos lo", `SFB_OP_OUTSTG, 16'hFFCE, 16'h0014, 16'h0000, 1'b0, 16'h0000);
    expect_op("gain sym", `SFB_OP_GAIN, 16'h0064, 16'h7530, 16'h0002, 1'b0, 16'h0000);
    expect_op("out sym lo", `SFB_OP_OUTSTG, 16'hFFCE, 16'h0014, 16'h0000, 1'b0, 16'hFFEC);
    expect_op("gain const", `SFB_OP_GAIN, 16'h0064, 16'h7530, 16'h0000, 1'b0, 16'h0000);
    expect_op("out const", `SFB_OP_OUTSTG, 16'h0032, 16'h0014, 16'h04D2, 1'b0, 16'h04D2);
    expect_op("gain const", `SFB_OP_GAIN, 16'h0064, 16'h7530, 16'h0000, 1'b0, 16'h0000);
    expect_op("out clamp", `SFB_OP_OUTSTG, 16'h0032, 16'h0014, 16'h9000, 1'b0, 16'h7FFF);
    expect_op("gain ti0", `SFB_OP_GAIN, 16'h0064, 16'h0000, 16'h0001, 1'b0, 16'hFFFF);
    expect_op("out bad", `SFB_OP_OUTSTG, 16'h0032, 16'h0014, 16'h0000, 1'b0, 16'h0000);
    expect_op("gain mode3", `SFB_OP_GAIN, 16'h0064, 16'h7530, 16'h0003, 1'b0, 16'hFFFF);
    expect_op("gain pos", `SFB_OP_GAIN, 16'h0064, 16'h7530, 16'h0001, 1'b0, 16'h0000);
    expect_op("between", `SFB_OP_SWITCH, 16'h0000, 16'h0000, 16'h0007, 1'b0, 16'h0007);
    expect_op("out gap", `SFB_OP_OUTSTG, 16'h0032, 16'h0014, 16'h0000, 1'b0, 16'h0000);
    expect_op("gain pos", `SFB_OP_GAIN, 16'h0064, 16'h7530, 16'h0001, 1'b0, 16'h0000);
    expect_op("out newloop", `SFB_OP_OUTSTG, 16'h0032, 16'h0014, 16'h0000, 1'b1, 16'h0000);
    expect_op("out first", `SFB_OP_OUTSTG, 16'h0032, 16'h0014, 16'h0000, 1'b0, 16'h0000);
  endtask

  task automatic up_count_case();
    expect_op("up off", `SFB_OP_UPCNT, 16'h0000, 16'h0001, 16'h0000, 1'b0, 16'h0000);
    expect_op("up rise", `SFB_OP_UPCNT, 16'h0001, 16'h0000, 16'h0000, 1'b0, 16'h0001);
    expect_op("up high", `SFB_OP_UPCNT, 16'h0001, 16'h0000, 16'h0000, 1'b0, 16'h0001);
    expect_op("up fall0", `SFB_OP_UPCNT, 16'h0000, 16'h0000, 16'h0000, 1'b0, 16'h0001);
    expect_op("up rise2", `SFB_OP_UPCNT, 16'h0001, 16'h0000, 16'h0000, 1'b0, 16'h0002);
    expect_op("up fall1", `SFB_OP_UPCNT, 16'h0000, 16'h0000, 16'h0001, 1'b0, 16'h0003);
    expect_op("up rise1", `SFB_OP_UPCNT, 16'h0001, 16'h0000, 16'h0001, 1'b0, 16'h0003);
    expect_op("up any f", `SFB_OP_UPCNT, 16'h0000, 16'h0000, 16'h0002, 1'b0, 16'h0004);
    expect_op("up any r", `SFB_OP_UPCNT, 16'h0001, 16'h0000, 16'h0002, 1'b0, 16'h0005);
    expect_op("up stop", `SFB_OP_UPCNT, 16'h0000, 16'h0001, 16'h0002, 1'b0, 16'h0000);
  endtask

  task automatic down_count_case();
    expect_op("dn load", `SFB_OP_DNCNT, 16'h0000, 16'h0001, 16'h0002, 1'b0, 16'h0002);
    expect_op("dn rise", `SFB_OP_DNCNT, 16'h0001, 16'h0000, 16'h0002, 1'b0, 16'h0001);
    expect_op("dn fall", `SFB_OP_DNCNT, 16'h0000, 16'h0000, 16'h0002, 1'b0, 16'h0001);
    expect_op("dn rise2", `SFB_OP_DNCNT, 16'h0001, 16'h0000, 16'h0002, 1'b0, 16'h0000);
    expect_op("dn fall2", `SFB_OP_DNCNT, 16'h0000, 16'h0000, 16'h0002, 1'b0, 16'h0000);
    expect_op("dn floor", `SFB_OP_DNCNT, 16'h0001, 16'h0000, 16'h0002, 1'b0, 16'h0000);
    expect_op("dn reload", `SFB_OP_DNCNT, 16'h0001, 16'h0001, 16'h0009, 1'b0, 16'h0009);
  endtask

  // a frozen block must neither take a step nor move its outputs
  task automatic ce_case();
    logic [15:0] held;
    held = result;
    ce = 1'b0;
    op_code = `SFB_OP_SWITCH;
    arg_a = 16'h0000;
    arg_b = 16'h0000;
    arg_c = 16'h00AA;
    step = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check_word("frozen busy", 16'h0000, {15'h0000, busy});
    check_word("frozen result", held, result);
    ce = 1'b1;
    expect_op("thawed", `SFB_OP_SWITCH, 16'h0000, 16'h0000, 16'h00AA, 1'b0, 16'h00AA);
  endtask

  // mid-run reset must clear counters, chain history and outputs
  task automatic reset_case();
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    check_word("rerst result", 16'h0000, result);
    check_word("rerst busy", 16'h0000, {15'h0000, busy});
    expect_op("rerst up", `SFB_OP_UPCNT, 16'h0001, 16'h0000, 16'h0000, 1'b0, 16'h0001);
    expect_op("rerst dn", `SFB_OP_DNCNT, 16'h0001, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    expect_op("rerst out", `SFB_OP_OUTSTG, 16'h0032, 16'h0014, 16'h0000, 1'b0, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    step = 1'b0;
    loop_start = 1'b0;
    op_code = 8'h00;
    arg_a = 16'h0000;
    arg_b = 16'h0000;
    arg_c = 16'h0000;
    errors = 0;
    comparisons = 0;
    repeat (10) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    check_word("reset result", 16'h0000, result);
    select_case();
    bit_case();
    smooth_case();
    regulator_case();
    up_count_case();
    down_count_case();
    ce_case();
    reset_case();
    print_verdict();
  end

  // 60 steps of at most 60 cycles each fit well inside this span
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("unexpected watchdog expired expected 0 seen 1");
    print_verdict();
  end

endmodule
